// ---- rtl/dfb_supervisor.sv ----
`timescale 1ns/1ns
module dfb_supervisor #(
    parameter int unsigned BOOT_TIMEOUT_CYC = dfb_pkg::BOOT_TIMEOUT_DEF,
    parameter int unsigned BUTTON_HOLD_CYC  = dfb_pkg::BUTTON_HOLD_DEF,
    parameter int unsigned OFF_HOLD_CYC     = dfb_pkg::OFF_HOLD_DEF,
    parameter int unsigned RTC_PULSE_CYC    = dfb_pkg::RTC_PULSE_DEF,
    parameter int unsigned BLINK_W          = dfb_pkg::BLINK_W_DEF
) (
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       boot_done_in,
    input  wire logic       front_button_in,
    input  wire logic       supply_low_in,
    input  wire logic       rails_out_of_spec_in,
    input  wire logic       sleep_s5_n_in,
    input  wire logic [1:0] stop_method_in,
    output logic            platform_power_enable_out,
    output logic            flash_select_out,
    output logic            power_button_out,
    output logic            rtc_reset_out,
    output logic            secondary_rtc_reset_out,
    output logic            core_power_good_out,
    output logic            resume_reset_n_out,
    output logic            deep_sleep_well_power_good_out,
    output logic            alarm_led_out
);
    import dfb_pkg::*;

    // refuse zero counts, whose minus one would wrap the timer
    if (BOOT_TIMEOUT_CYC == 0 || BUTTON_HOLD_CYC == 0 || OFF_HOLD_CYC == 0 || RTC_PULSE_CYC == 0)
    begin : g_bad_count
        $error("dfb_supervisor: every count must be at least one cycle");
    end
    if (BLINK_W < 2 || BLINK_W > 32)
    begin : g_bad_blink
        $error("dfb_supervisor: BLINK_W must lie in 2..32");
    end

    logic [SYNC_W-1:0]  sync_meta;
    logic [SYNC_W-1:0]  sync;
    logic               boot_done_s;
    logic               button_s;
    logic               supply_low_s;
    logic               rails_gone_s;
    logic               s5_n_s;
    logic [1:0]         method_s;
    logic               button_prev;
    logic               button_press;
    dfb_state_t         state;
    dfb_state_t         next_state;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    logic               timer_done;
    logic               platform_power_enable;
    logic               next_platform_power_enable;
    logic               flash_sel;
    logic               next_flash_sel;
    logic               pbtn;
    logic               next_pbtn;
    logic               rtc;
    logic               next_rtc;
    logic               core_pg;
    logic               next_core_pg;
    logic               rsm_n;
    logic               next_rsm_n;
    logic               dsw_pg;
    logic               next_dsw_pg;
    logic               alarm;
    logic               next_alarm;
    logic               pend_switch;
    logic               next_pend_switch;
    logic               pend_rtc;
    logic               next_pend_rtc;
    logic [BLINK_W-1:0] blink;
    logic               led;

    // every pin input crosses two flops before use
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sync_meta   <= '0;
            sync        <= '0;
            button_prev <= 1'b0;
        end
        else
        begin
            sync_meta   <= {stop_method_in, rails_out_of_spec_in, supply_low_in, sleep_s5_n_in,
                            front_button_in, boot_done_in};
            sync        <= sync_meta;
            button_prev <= button_s;
        end
    end

    assign boot_done_s  = sync[0];
    assign button_s     = sync[1];
    assign s5_n_s       = sync[2];
    assign supply_low_s = sync[3];
    assign rails_gone_s = sync[4];
    assign method_s     = sync[6:5];
    assign button_press = button_s & ~button_prev;  // one press, one action
    assign timer_done   = (timer == '0);

    // sequencer next state
    always_comb
    begin
        next_state       = state;
        next_timer       = timer_done ? timer : timer - 1'b1;
        next_platform_power_enable      = platform_power_enable;
        next_flash_sel   = flash_sel;
        next_pbtn        = pbtn;
        next_rtc         = rtc;
        next_core_pg     = core_pg;
        next_rsm_n       = rsm_n;
        next_dsw_pg      = dsw_pg;
        next_alarm       = alarm;
        next_pend_switch = pend_switch;
        next_pend_rtc    = pend_rtc;
        unique case (state)
            ST_G3:
            begin
                next_platform_power_enable = 1'b1;
                next_timer  = TIMER_W'(POWER_UP_CYC - 1);
                next_state  = ST_POWERUP;
            end
            ST_POWERUP:
                if (timer_done)
                begin
                    next_dsw_pg = 1'b1;
                    next_rsm_n  = 1'b1;
                    next_timer  = TIMER_W'(INTERVAL_ONE_CYC - 1);
                    next_state  = ST_CORE_UP;
                end
            ST_CORE_UP:
                if (timer_done)
                begin
                    next_core_pg = 1'b1;
                    next_timer   = TIMER_W'(BOOT_TIMEOUT_CYC - 1);
                    next_state   = ST_BOOT;
                end
            ST_BOOT:
                if (boot_done_s)
                begin
                    next_alarm = 1'b0;
                    next_state = ST_RUN;
                end
                else if (timer_done)
                begin
                    next_alarm = 1'b1;
                    if (!flash_sel)
                    begin
                        next_pend_switch = 1'b1;
                        if (method_s == STOP_BUTTON_HOLD)
                        begin
                            next_pbtn  = 1'b1;
                            next_timer = TIMER_W'(BUTTON_HOLD_CYC - 1);
                            next_state = ST_BTN_HOLD;
                        end
                        else
                        begin
                            next_pend_rtc = (method_s == STOP_RTC_GLOBAL);
                            next_core_pg  = 1'b0;
                            next_timer    = TIMER_W'(CORE_TO_S5_CYC - 1);
                            next_state    = ST_SD_CORE;
                        end
                    end
                    else
                        next_state = ST_FAULT;  // backup failed too, wait for the operator
                end
            ST_RUN:
                next_state = ST_RUN;
            ST_FAULT:
                if (button_press)
                begin
                    next_pend_rtc = 1'b1;
                    next_core_pg  = 1'b0;
                    next_timer    = TIMER_W'(CORE_TO_S5_CYC - 1);
                    next_state    = ST_SD_CORE;
                end
            ST_BTN_HOLD:
                if (timer_done)
                begin
                    next_pbtn    = 1'b0;
                    next_core_pg = 1'b0;
                    next_timer   = TIMER_W'(CORE_TO_S5_CYC - 1);
                    next_state   = ST_SD_CORE;
                end
            // wait 60 us and s5, then both fall
            ST_SD_CORE:
                if (timer_done && !s5_n_s)
                begin
                    next_rsm_n  = 1'b0;
                    next_dsw_pg = 1'b0;
                    next_timer  = TIMER_W'(RAIL_CYC - 1);
                    next_state  = ST_SD_RAIL;
                end
            // rails go only after the intervals
            ST_SD_RAIL:
                if (timer_done)
                begin
                    next_platform_power_enable = 1'b0;
                    next_timer  = TIMER_W'(OFF_HOLD_CYC - 1);
                    next_state  = ST_OFF_HOLD;
                end
            ST_OFF_HOLD:
                if (timer_done)
                begin
                    if (pend_rtc)
                    begin
                        // both rtc resets, in G3 only
                        next_rtc   = 1'b1;
                        next_timer = TIMER_W'(RTC_PULSE_CYC - 1);
                        next_state = ST_RTC;
                    end
                    else
                    begin
                        // switch mux while power is off
                        if (pend_switch)
                            next_flash_sel = 1'b1;
                        next_pend_switch = 1'b0;
                        next_state       = ST_G3;
                    end
                end
            ST_RTC:
                if (timer_done)
                begin
                    next_rtc      = 1'b0;
                    next_pend_rtc = 1'b0;
                    next_timer    = TIMER_W'(INTERVAL_ONE_CYC - 1);
                    next_state    = ST_OFF_HOLD;
                end
            ST_LOCKOUT:
                if (rails_gone_s && !supply_low_s)
                begin
                    next_timer = TIMER_W'(OFF_HOLD_CYC - 1);
                    next_state = ST_OFF_HOLD;
                end
        endcase
        // supply sag overrides any step, all goods drop at once
        if (supply_low_s && state != ST_LOCKOUT)
        begin
            next_core_pg = 1'b0;
            next_rsm_n   = 1'b0;
            next_dsw_pg  = 1'b0;
            next_platform_power_enable  = 1'b0;
            next_pbtn    = 1'b0;
            next_rtc     = 1'b0;
            next_state   = ST_LOCKOUT;
        end
    end

    // sequencer registers; reset leaves power off on flash 0
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            state       <= ST_G3;
            timer       <= '0;
            platform_power_enable      <= 1'b0;
            flash_sel   <= 1'b0;  // flash 0 by default
            pbtn        <= 1'b0;
            rtc         <= 1'b0;
            core_pg     <= 1'b0;
            rsm_n       <= 1'b0;
            dsw_pg      <= 1'b0;
            alarm       <= 1'b0;
            pend_switch <= 1'b0;
            pend_rtc    <= 1'b0;
            blink       <= '0;
            led         <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            timer       <= next_timer;
            platform_power_enable      <= next_platform_power_enable;
            flash_sel   <= next_flash_sel;
            pbtn        <= next_pbtn;
            rtc         <= next_rtc;
            core_pg     <= next_core_pg;
            rsm_n       <= next_rsm_n;
            dsw_pg      <= next_dsw_pg;
            alarm       <= next_alarm;
            pend_switch <= next_pend_switch;
            pend_rtc    <= next_pend_rtc;
            blink       <= blink + 1'b1;
            led         <= next_alarm & blink[BLINK_W-1];  // slow blink while alarmed
        end
    end

    // outputs straight from flops
    assign platform_power_enable_out      = platform_power_enable;
    assign flash_select_out               = flash_sel;
    assign power_button_out               = pbtn;
    assign rtc_reset_out                  = rtc;
    assign secondary_rtc_reset_out        = rtc;
    assign core_power_good_out            = core_pg;
    assign resume_reset_n_out             = rsm_n;
    assign deep_sleep_well_power_good_out = dsw_pg;
    assign alarm_led_out                  = led;

    // helper: cycles since core good and resume reset fell, saturating
    logic [15:0] core_low_cnt;
    logic [15:0] rsm_low_cnt;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            core_low_cnt <= '0;
            rsm_low_cnt  <= '0;
        end
        else
        begin
            core_low_cnt <= core_pg ? '0 : (core_low_cnt == 16'hffff ? core_low_cnt : core_low_cnt + 1'b1);
            rsm_low_cnt  <= rsm_n ? '0 : (rsm_low_cnt == 16'hffff ? rsm_low_cnt : rsm_low_cnt + 1'b1);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_flash_rise_on_fail;
        $rose(flash_sel) |-> alarm && !platform_power_enable;
    endproperty
    a_flash_rise_on_fail: assert property (p_flash_rise_on_fail) else $error("flash 1 chosen without a failed boot");

    property p_mux_only_off;
        $changed(flash_sel) |-> !platform_power_enable ##1 (platform_power_enable && state == ST_POWERUP);
    endproperty
    a_mux_only_off: assert property (p_mux_only_off) else $error("flash mux moved with power on");

    property p_core_to_resume;
        ($fell(rsm_n) && state != ST_LOCKOUT) |-> core_low_cnt >= 16'(CORE_TO_S5_CYC) && !s5_n_s;
    endproperty
    a_core_to_resume: assert property (p_core_to_resume) else $error("resume reset fell too early");

    property p_resume_with_dsw;
        $fell(rsm_n) |-> $fell(dsw_pg);
    endproperty
    a_resume_with_dsw: assert property (p_resume_with_dsw) else $error("resume and deep-sleep good apart");

    property p_rail_intervals;
        ($fell(platform_power_enable) && state == ST_OFF_HOLD) |-> rsm_low_cnt >= 16'(RAIL_CYC) && !core_pg;
    endproperty
    a_rail_intervals: assert property (p_rail_intervals) else $error("power removed before intervals");

    property p_sag_drop;
        supply_low_s |=> !core_pg && !rsm_n && !dsw_pg && !platform_power_enable;
    endproperty
    a_sag_drop: assert property (p_sag_drop) else $error("power goods not dropped on sag");

    property p_lockout;
        (state == ST_LOCKOUT && !rails_gone_s) |=> state == ST_LOCKOUT && !core_pg && !rsm_n && !dsw_pg;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout left before rails gone");

    property p_rtc_in_g3;
        rtc |-> !platform_power_enable && !dsw_pg && rtc_reset_out == secondary_rtc_reset_out;
    endproperty
    a_rtc_in_g3: assert property (p_rtc_in_g3) else $error("rtc reset outside G3");

    property p_done_stops_wd;
        (state == ST_BOOT && boot_done_s && !supply_low_s) |=> state == ST_RUN && !alarm;
    endproperty
    a_done_stops_wd: assert property (p_done_stops_wd) else $error("boot-done did not stop watchdog");

    property p_button_hold;
        ($rose(pbtn) && !supply_low_s) |=> pbtn [*8];
    endproperty
    a_button_hold: assert property (p_button_hold) else $error("power button released early");

    property p_alarm_cause;
        $rose(alarm) |-> $past(state) == ST_BOOT && $past(timer_done) && !$past(boot_done_s);
    endproperty
    a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without expiry");
endmodule

// ---- rtl/dfb_pkg.sv ----
package dfb_pkg;
    // system clock
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 20;

    // shutdown and power-up timing, least times
    localparam int unsigned CORE_TO_S5_NS   = 60_000;
    localparam int unsigned INTERVAL_ONE_NS = 1_000;
    localparam int unsigned INTERVAL_TWO_NS = 100;
    localparam int unsigned INTERVAL_THR_NS = 400;
    localparam int unsigned POWER_UP_NS     = 10_000;

    // long times, become module parameters
    localparam int unsigned BOOT_TIMEOUT_S  = 30;
    localparam int unsigned BUTTON_HOLD_S   = 6;
    localparam int unsigned OFF_HOLD_MS     = 500;
    localparam int unsigned RTC_PULSE_US    = 1_000;

    // least time rounds up, never below one cycle
    function automatic int unsigned min_cyc(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c == 0) ? 1 : c;
    endfunction

    localparam int unsigned CORE_TO_S5_CYC   = min_cyc(CORE_TO_S5_NS);
    localparam int unsigned INTERVAL_ONE_CYC = min_cyc(INTERVAL_ONE_NS);
    localparam int unsigned RAIL_CYC         = min_cyc(INTERVAL_ONE_NS) + min_cyc(INTERVAL_TWO_NS)
                                               + min_cyc(INTERVAL_THR_NS);
    localparam int unsigned POWER_UP_CYC     = min_cyc(POWER_UP_NS);
    localparam int unsigned BOOT_TIMEOUT_DEF = BOOT_TIMEOUT_S * CLK_HZ;
    localparam int unsigned BUTTON_HOLD_DEF  = BUTTON_HOLD_S * CLK_HZ;
    localparam int unsigned OFF_HOLD_DEF     = OFF_HOLD_MS * (CLK_HZ / 1_000);
    localparam int unsigned RTC_PULSE_DEF    = RTC_PULSE_US * (CLK_HZ / 1_000_000);

    // stop method strap codes
    localparam logic [1:0] STOP_POWER_CYCLE = 2'h0;
    localparam logic [1:0] STOP_BUTTON_HOLD = 2'h1;
    localparam logic [1:0] STOP_RTC_GLOBAL  = 2'h2;

    localparam int unsigned TIMER_W = 32;
    localparam int unsigned SYNC_W  = 7;
    localparam int unsigned BLINK_W_DEF = 24;

    typedef enum logic [3:0] {
        ST_G3, ST_POWERUP, ST_CORE_UP, ST_BOOT, ST_RUN, ST_FAULT, ST_BTN_HOLD,
        ST_SD_CORE, ST_SD_RAIL, ST_OFF_HOLD, ST_RTC, ST_LOCKOUT
    } dfb_state_t;
endpackage

// ---- tb/dfb_hub_model.sv ----
`timescale 1ns/1ns
module dfb_hub_model (
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    input  wire logic        core_power_good_in,
    input  wire logic        boot_ok_in,
    input  wire logic [15:0] s5_delay_in,
    output logic             sleep_s5_n_out,
    output logic             boot_done_out
);
    logic [15:0] s5_count;
    logic [7:0]  fw_count;

    // hub and firmware act on the falling edge; a hub without core power reads as asleep after s5_delay_in plus one edges
    always @(negedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            s5_count       <= 16'h0000;
            fw_count       <= 8'h00;
            sleep_s5_n_out <= 1'b0;
            boot_done_out  <= 1'b0;
        end
        else if (core_power_good_in)
        begin
            s5_count       <= 16'h0000;
            sleep_s5_n_out <= 1'b1;
            if (fw_count != 8'hff)
                fw_count <= fw_count + 8'h01;
            boot_done_out <= boot_ok_in && (fw_count >= 8'h64);
        end
        else
        begin
            // slow hubs are modelled by a long delay, so the supervisor must wait for sleep s5
            fw_count      <= 8'h00;
            boot_done_out <= 1'b0;
            if (s5_count != s5_delay_in)
                s5_count <= s5_count + 16'h0001;
            else
                sleep_s5_n_out <= 1'b0;
        end
    end
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    import dfb_pkg::*;
    localparam int BOOT_CYC = 2000;
    localparam int HOLD_CYC = 20;
    localparam int RTC_CYC  = 10;
    localparam int P_PWR    = 0;
    localparam int P_CORE   = 1;
    localparam int P_RES    = 2;
    localparam int P_FLASH  = 3;
    localparam int P_BTN    = 4;
    localparam int P_RTC    = 5;
    localparam int P_ALARM  = 6;

    logic        clk_in, sys_rst_in, boot_done_in, front_button_in, supply_low_in;
    logic        rails_out_of_spec_in, sleep_s5_n_in, boot_ok, prev_flash;
    logic [1:0]  stop_method_in;
    logic [15:0] s5_delay;
    logic        platform_power_enable, flash_sel, pwr_btn, rtc_rst, rtc2_rst, core_pg, resume_n, dsw_pg, alarm;
    int          fails, check_count, cycles;

    dfb_supervisor #(.BOOT_TIMEOUT_CYC(BOOT_CYC), .BUTTON_HOLD_CYC(HOLD_CYC), .OFF_HOLD_CYC(10),
                     .RTC_PULSE_CYC(RTC_CYC), .BLINK_W(3)) dfb_supervisor_inst (
        .clk_in                         (clk_in),
        .sys_rst_in                     (sys_rst_in),
        .boot_done_in                   (boot_done_in),
        .front_button_in                (front_button_in),
        .supply_low_in                  (supply_low_in),
        .rails_out_of_spec_in           (rails_out_of_spec_in),
        .sleep_s5_n_in                  (sleep_s5_n_in),
        .stop_method_in                 (stop_method_in),
        .platform_power_enable_out      (platform_power_enable),
        .flash_select_out               (flash_sel),
        .power_button_out               (pwr_btn),
        .rtc_reset_out                  (rtc_rst),
        .secondary_rtc_reset_out        (rtc2_rst),
        .core_power_good_out            (core_pg),
        .resume_reset_n_out             (resume_n),
        .deep_sleep_well_power_good_out (dsw_pg),
        .alarm_led_out                  (alarm)
    );

    dfb_hub_model dfb_hub_model_inst (
        .clk_in             (clk_in),
        .sys_rst_in         (sys_rst_in),
        .core_power_good_in (core_pg),
        .boot_ok_in         (boot_ok),
        .s5_delay_in        (s5_delay),
        .sleep_s5_n_out     (sleep_s5_n_in),
        .boot_done_out      (boot_done_in)
    );

    // comparison helpers, four-state so an unknown never matches a known value
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic check_in(input string what, input int n, input int lo, input int hi);
        check_count++;
        if (n < lo || n > hi)
        begin
            fails++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, n);
        end
    endtask

    function automatic logic pick(input int k);
        case (k)
            P_PWR:   return platform_power_enable;
            P_CORE:  return core_pg;
            P_RES:   return resume_n;
            P_FLASH: return flash_sel;
            P_BTN:   return pwr_btn;
            P_RTC:   return rtc_rst;
            default: return alarm;
        endcase
    endfunction

    // bounded wait for an output level, counted in falling edges
    task automatic wait_for(input string what, input int k, input logic lvl, input int limit, output int n);
        n = 0;
        while (pick(k) !== lvl && n < limit)
        begin
            @(negedge clk_in);
            n++;
        end
        check(what, {31'h0, lvl}, {31'h0, pick(k)});
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic do_reset(input logic [1:0] method, input logic [15:0] delay);
        @(negedge clk_in);
        sys_rst_in = 1'b1;
        boot_ok = 1'b0;
        supply_low_in = 1'b0;
        rails_out_of_spec_in = 1'b0;
        stop_method_in = method;
        s5_delay = delay;
        repeat (8) @(negedge clk_in);
        check("flash in reset", 32'h0, {31'h0, flash_sel});
        sys_rst_in = 1'b0;
    endtask

    // graceful shutdown from the core good fall onwards
    task automatic shut_down(input int delay);
        int n;
        int lo;
        lo = (delay > CORE_TO_S5_CYC) ? delay : CORE_TO_S5_CYC;
        wait_for("resume low", P_RES, 1'b0, 5000, n);
        check_in("core to resume gap", n, lo, lo + 6);
        check("power at resume fall", 32'h1, {31'h0, platform_power_enable});
        wait_for("power off", P_PWR, 1'b0, 200, n);
        check_in("rail intervals", n, RAIL_CYC, RAIL_CYC + 2);
    endtask

    task automatic rtc_pulse();
        int n;
        wait_for("rtc high", P_RTC, 1'b1, 100, n);
        wait_for("rtc low", P_RTC, 1'b0, 40, n);
        check_in("rtc pulse length", n, RTC_CYC - 1, RTC_CYC + 1);
    endtask

    task automatic t_boot_ok();
        int n;
        do_reset(2'h0, 16'h0064);
        boot_ok = 1'b1;
        wait_for("core good up", P_CORE, 1'b1, 700, n);
        check("flash zero", 32'h0, {31'h0, flash_sel});
        repeat (BOOT_CYC + 500) @(negedge clk_in);
        check("power kept", 32'h1, {31'h0, core_pg});
        check("no alarm", 32'h0, {31'h0, alarm});
        $display("test boot_ok done");
    endtask

    task automatic t_timeout(input logic [1:0] method, input logic [15:0] delay, input logic recover);
        int n;
        do_reset(method, delay);
        wait_for("core good up", P_CORE, 1'b1, 700, n);
        if (method == 2'h1)
        begin
            wait_for("button held", P_BTN, 1'b1, BOOT_CYC + 10, n);
            check_in("expiry", n, BOOT_CYC - 2, BOOT_CYC + 2);
            wait_for("button freed", P_BTN, 1'b0, 40, n);
            check_in("button hold", n, HOLD_CYC - 1, HOLD_CYC + 1);
        end
        wait_for("core good down", P_CORE, 1'b0, BOOT_CYC + 10, n);
        if (method != 2'h1)
            check_in("expiry", n, BOOT_CYC - 2, BOOT_CYC + 2);
        shut_down(int'(delay));
        if (method == 2'h2)
            rtc_pulse();
        check("flash before switch", 32'h0, {31'h0, flash_sel});
        wait_for("backup chosen", P_FLASH, 1'b1, 300, n);
        wait_for("power back", P_PWR, 1'b1, 50, n);
        wait_for("core good again", P_CORE, 1'b1, 700, n);
        wait_for("alarm lit", P_ALARM, 1'b1, 16, n);
        boot_ok = recover;
        repeat (BOOT_CYC + 200) @(negedge clk_in);
        check("power kept", 32'h1, {31'h0, platform_power_enable});
        check("flash one kept", 32'h1, {31'h0, flash_sel});
        if (recover)
            check("alarm cleared", 32'h0, {31'h0, alarm});
        $display("test timeout method %0h done", method);
    endtask

    task automatic t_fault();
        int n;
        t_timeout(2'h0, 16'h0064, 1'b0);
        // two edges cover the synchroniser; the gap is then timed from the core good fall
        front_button_in = 1'b1;
        repeat (2) @(negedge clk_in);
        front_button_in = 1'b0;
        wait_for("core good down", P_CORE, 1'b0, 10, n);
        shut_down(100);
        rtc_pulse();
        wait_for("power back", P_PWR, 1'b1, 100, n);
        check("flash one kept", 32'h1, {31'h0, flash_sel});
        $display("test fault button done");
    endtask

    task automatic t_emergency();
        int n;
        do_reset(2'h0, 16'h0064);
        boot_ok = 1'b1;
        wait_for("core good up", P_CORE, 1'b1, 700, n);
        repeat (200) @(negedge clk_in);
        supply_low_in = 1'b1;
        wait_for("core good cut", P_CORE, 1'b0, 6, n);
        check_in("sag latency", n, 2, 4);
        check("resume cut", 32'h0, {31'h0, resume_n});
        check("power cut", 32'h0, {31'h0, platform_power_enable});
        repeat (50) @(negedge clk_in);
        supply_low_in = 1'b0;
        repeat (50) @(negedge clk_in);
        check("locked out", 32'h0, {31'h0, dsw_pg});
        rails_out_of_spec_in = 1'b1;
        wait_for("power after lockout", P_PWR, 1'b1, 40, n);
        wait_for("core good after lockout", P_CORE, 1'b1, 700, n);
        $display("test emergency done");
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // relations that must hold on every cycle out of reset
    always @(negedge clk_in)
    begin
        if (!sys_rst_in)
        begin
            check("resume with deep sleep good", {31'h0, dsw_pg}, {31'h0, resume_n});
            check("rtc pair", {31'h0, rtc_rst}, {31'h0, rtc2_rst});
            if (rtc_rst !== 1'b0)
                check("rtc only in g3", 32'h0, {31'h0, platform_power_enable});
            if (flash_sel !== prev_flash)
                check("flash moved powered", 32'h0, {31'h0, platform_power_enable});
        end
        prev_flash = flash_sel;
    end

    // a hang is cut well above the expected run of about 50000 cycles
    always @(posedge clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 90000)
        begin
            fails++;
            $display("CHECK FAILED run length expected below 90000 seen %0d", cycles);
            summarize();
        end
    end

    initial
    begin
        fails = 0;
        check_count = 0;
        cycles = 0;
        prev_flash = 1'b0;
        sys_rst_in = 1'b1;
        boot_ok = 1'b0;
        front_button_in = 1'b0;
        supply_low_in = 1'b0;
        rails_out_of_spec_in = 1'b0;
        stop_method_in = 2'h0;
        s5_delay = 16'h0064;
        t_boot_ok();
        t_timeout(2'h0, 16'h0064, 1'b1);
        t_timeout(2'h0, 16'h0dac, 1'b1);
        t_timeout(2'h1, 16'h0064, 1'b1);
        t_timeout(2'h2, 16'h0064, 1'b1);
        t_fault();
        t_emergency();
        summarize();
    end
endmodule
